// file: logic/fer_defs.svh
// constants of the fault event recorder: sizes, widths and timing counts
`ifndef FER_DEFS_SVH
`define FER_DEFS_SVH

`define FER_NUM_RECORDS 20
`define FER_NUM_MODULES 8
`define FER_TIME_W 16
`define FER_SEQ_W 16
`define FER_MEAS_W 16
`define FER_CLK_PERIOD_PS 10000
`define FER_TICK_TIME_PS 1000000000
`define FER_TICK_CYCLES (`FER_TICK_TIME_PS / `FER_CLK_PERIOD_PS)

`endif

// file: logic/fer_pkg.sv
// types shared by the fault event recorder files
package fer_pkg;

  // recorder phase of the open fault, one-hot
  typedef enum logic [2:0] {
    FER_IDLE   = 3'b001,
    FER_ACTIVE = 3'b010,
    FER_SETTLE = 3'b100
  } fer_state_e;

  // one stored fault record
  typedef struct packed {
    logic [15:0] seq;
    logic [15:0] grid;
    logic [15:0] ttt;
    logic        ttt_valid;
    logic [15:0] dur;
    logic [15:0] meas;
    logic        tripped;
    logic        changed;
  } fer_rec_s;

endpackage

// file: logic/fer_timer.sv
// saturating millisecond interval counter
`timescale 1ns/100ps
`default_nettype none

module fer_timer #(
  parameter int TW = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic run,
  input wire logic tick,
  output logic [TW-1:0] value
);

  logic [TW-1:0] next_value;

  // clear wins; saturate so a very long fault never wraps to a short time
  always_comb begin
    next_value = value;
    if (clear) begin
      next_value = '0;
    end else if (run && tick && value != {TW{1'b1}}) begin
      next_value = value + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value <= '0;
    end else begin
      value <= next_value;
    end
  end

endmodule
`default_nettype wire

// file: logic/fer_recorder.sv
// fault event recorder: opens, times, captures and stores fault records
//
// What this block does
// - A rising edge of the combined pickup opens a new fault record, except while the previous one still waits in FER_SETTLE.
// - Combined pickup is the OR of all module pickups, combined trip the OR of all trips.
// - Measurements are stored into the open record when the trip decision is taken.
// - A nonzero capture delay postpones that storing by the delay after the trip.
// - In any-pickup mode a record is kept even if no trip followed the pickup.
// - In trips-only mode a record without a trip is discarded.
// - Closing a fault (falling combined pickup, or the delayed capture after it) raises a notification held until ack, also for a discarded record.
// - Time to trip is measured from first pickup to first trip and stored.
// - Fault duration is measured from rising to falling combined pickup.
// - Time to trip is left empty when pickup and trip came from different modules.
// - At most 20 records are held and a new one replaces the oldest when full.
// - The newest record is also kept in a separate retained copy.
// - Every record carries a flag telling whether the fault tripped.
// - Every record carries the fault number and the grid fault number.
// - Settings are not stored; a settings change marks stored records as changed.
// - The fault sequence number increments with every new fault.
`timescale 1ns/100ps
`default_nettype none
`include "fer_defs.svh"

module fer_recorder
  import fer_pkg::*;
#(
  parameter int NMOD = `FER_NUM_MODULES,
  parameter int NREC = `FER_NUM_RECORDS,
  parameter int TICK_CYCLES = `FER_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [NMOD-1:0] mod_pickup,
  input wire logic [NMOD-1:0] mod_trip,
  input wire logic [15:0] meas_value,
  input wire logic [15:0] meas_delay_ms,
  input wire logic record_any_pickup,
  input wire logic ar_cycle_active,
  input wire logic settings_changed,
  input wire logic notify_ack,
  input wire logic [4:0] rd_age,
  output logic pickup_any,
  output logic trip_any,
  output logic notify,
  output logic [15:0] notify_seq,
  output logic [4:0] record_count,
  output logic rd_valid,
  output fer_rec_s rd_rec,
  output logic nv_valid,
  output fer_rec_s nv_rec
);

  localparam int IW = (NMOD > 1) ? $clog2(NMOD) : 1;

  // refuse sizes the 5-bit count and age ports cannot serve
  if (NMOD < 1 || NREC < 2 || NREC > 31 || TICK_CYCLES < 1) begin : g_check
    $error("fer_recorder: unsupported parameter value");
  end

  fer_state_e state, next_state;
  fer_rec_s cur, next_cur;
  fer_rec_s store [NREC];
  fer_rec_s next_store [NREC];
  fer_rec_s next_rd_rec, next_nv_rec;
  logic [15:0] seq, next_seq, grid, next_grid, next_notify_seq;
  logic [IW-1:0] first_idx, next_first_idx;
  logic [4:0] head, next_head, next_record_count;
  logic delay_pend, next_delay_pend, meas_done, next_meas_done;
  logic next_notify, next_rd_valid, next_nv_valid;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic pu_now, tr_now, pu_rise;
  logic do_capture, do_commit, keep, trip_first, delay_over;
  logic [15:0] ttt_val, dur_val, dly_val;
  logic [4:0] rd_addr;
  logic [5:0] rd_sum;

  // millisecond enable pulse from the system clock
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'h0000_0001;
    if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  assign pu_now = |mod_pickup;
  assign tr_now = |mod_trip;
  assign pu_rise = pu_now && !pickup_any;

  // time to trip runs until the first trip
  fer_timer #(.TW(16)) u_ttt (
    .clock(clock), .reset_n(reset_n), .clear(pu_rise && state == FER_IDLE),
    .run(state == FER_ACTIVE && !cur.tripped), .tick(tick), .value(ttt_val)
  );
  fer_timer #(.TW(16)) u_dur (
    .clock(clock), .reset_n(reset_n), .clear(pu_rise && state == FER_IDLE),
    .run(state == FER_ACTIVE), .tick(tick), .value(dur_val)
  );
  // capture delay runs from the trip decision
  fer_timer #(.TW(16)) u_dly (
    .clock(clock), .reset_n(reset_n), .clear(!delay_pend),
    .run(delay_pend), .tick(tick), .value(dly_val)
  );

  assign trip_first = (state == FER_ACTIVE) && tr_now && !cur.tripped;
  assign delay_over = delay_pend && (dly_val >= meas_delay_ms);
  // newest-first read index
  // six bits, since head plus depth overflows the five-bit index
  assign rd_sum = 6'(head) + 6'(NREC) - 6'd1 - 6'(rd_age);
  assign rd_addr = (rd_sum >= 6'(NREC)) ? 5'(rd_sum - 6'(NREC)) : rd_sum[4:0];

  // fault sequencing, capture and storing
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_seq = seq;
    next_grid = grid;
    next_first_idx = first_idx;
    next_delay_pend = delay_pend;
    next_meas_done = meas_done;
    next_store = store;
    next_head = head;
    next_record_count = record_count;
    next_notify = notify;
    next_notify_seq = notify_seq;
    next_nv_rec = nv_rec;
    next_nv_valid = nv_valid;
    do_capture = 1'b0;
    do_commit = 1'b0;
    keep = 1'b0;
    case (state)
      FER_IDLE: begin
        if (pu_rise) begin
          next_state = FER_ACTIVE;
          next_seq = seq + 16'h0001;
          // reclose cycles stay on the same grid fault
          if (!ar_cycle_active) begin
            next_grid = grid + 16'h0001;
          end
          next_cur = '0;
          next_cur.seq = seq + 16'h0001;
          next_cur.grid = ar_cycle_active ? grid : grid + 16'h0001;
          next_delay_pend = 1'b0;
          next_meas_done = 1'b0;
          // lowest index wins when several modules pick up together
          for (int i = NMOD - 1; i >= 0; i--) begin
            if (mod_pickup[i]) begin
              next_first_idx = IW'(i);
            end
          end
        end
      end
      FER_ACTIVE: begin
        if (trip_first) begin
          next_cur.tripped = 1'b1;
          next_cur.ttt = ttt_val;
          next_cur.ttt_valid = mod_trip[first_idx];
          if (meas_delay_ms != 16'h0000) begin
            next_delay_pend = 1'b1;
          end else begin
            do_capture = 1'b1;
          end
        end
        if (delay_over) begin
          do_capture = 1'b1;
        end
        if (!pu_now) begin
          next_cur.dur = dur_val;
          if (delay_pend && !delay_over) begin
            next_state = FER_SETTLE;
          end else if (trip_first && meas_delay_ms != 16'h0000) begin
            next_state = FER_SETTLE;
          end else begin
            do_commit = 1'b1;
          end
        end
      end
      FER_SETTLE: begin
        // pickup already gone, waiting only for the delayed capture
        if (delay_over) begin
          do_capture = 1'b1;
          do_commit = 1'b1;
        end
      end
      default: begin
        next_state = FER_IDLE;
      end
    endcase
    if (do_capture && !meas_done) begin
      next_cur.meas = meas_value;
      next_meas_done = 1'b1;
      next_delay_pend = 1'b0;
    end
    // settings shown with old records may be stale
    if (settings_changed) begin
      for (int i = 0; i < NREC; i++) begin
        next_store[i].changed = 1'b1;
      end
      next_nv_rec.changed = 1'b1;
    end
    // ack clears, a simultaneous new notification wins
    if (notify_ack) begin
      next_notify = 1'b0;
    end
    // a trip in the very cycle the pickup falls still counts as tripped
    keep = next_cur.tripped || record_any_pickup;
    if (do_commit) begin
      next_state = FER_IDLE;
      next_delay_pend = 1'b0;
      if (keep) begin
        next_store[head] = next_cur;
        next_head = (head == 5'(NREC - 1)) ? 5'd0 : head + 5'd1;
        if (record_count != 5'(NREC)) begin
          next_record_count = record_count + 5'd1;
        end
        next_nv_rec = next_cur;
        next_nv_valid = 1'b1;
        next_notify_seq = next_cur.seq;
      end
      next_notify = 1'b1;
    end
    next_rd_valid = rd_age < record_count;
    next_rd_rec = next_rd_valid ? store[rd_addr] : '0;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= FER_IDLE;
      cur <= '0;
      seq <= '0;
      grid <= '0;
      first_idx <= '0;
      delay_pend <= 1'b0;
      meas_done <= 1'b0;
      store <= '{default: '0};
      head <= '0;
      record_count <= '0;
      notify <= 1'b0;
      notify_seq <= '0;
      nv_rec <= '0;
      nv_valid <= 1'b0;
      rd_rec <= '0;
      rd_valid <= 1'b0;
      pickup_any <= 1'b0;
      trip_any <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      seq <= next_seq;
      grid <= next_grid;
      first_idx <= next_first_idx;
      delay_pend <= next_delay_pend;
      meas_done <= next_meas_done;
      store <= next_store;
      head <= next_head;
      record_count <= next_record_count;
      notify <= next_notify;
      notify_seq <= next_notify_seq;
      nv_rec <= next_nv_rec;
      nv_valid <= next_nv_valid;
      rd_rec <= next_rd_rec;
      rd_valid <= next_rd_valid;
      pickup_any <= pu_now;
      trip_any <= tr_now;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_OPEN_RECORD: assert property (pu_rise && state == FER_IDLE |=> state == FER_ACTIVE)
    else $error("pickup edge did not open a record");
  AST_COMBINED_OR: assert property (1'b1 |=> pickup_any == $past(|mod_pickup)
    && trip_any == $past(|mod_trip))
    else $error("combined indication is not the OR of modules");
  AST_SEQ_STEP: assert property (pu_rise && state == FER_IDLE
    |=> seq == $past(seq) + 16'h0001 && cur.seq == seq)
    else $error("fault number did not step");
  AST_CAPTURE_NOW: assert property (trip_first && meas_delay_ms == 16'h0000
    && !meas_done |=> meas_done && cur.meas == $past(meas_value))
    else $error("measurement not captured at trip");
  AST_CAPTURE_LATER: assert property (trip_first && meas_delay_ms != 16'h0000
    |=> !meas_done && delay_pend)
    else $error("delayed capture happened early");
  AST_MEAS_ONCE: assert property (meas_done && state != FER_IDLE
    |=> cur.meas == $past(cur.meas))
    else $error("measurement overwritten within a fault");
  AST_DISCARD: assert property (do_commit && !keep
    |=> record_count == $past(record_count) && head == $past(head))
    else $error("untripped record stored in trips-only mode");
  AST_KEEP_ANY: assert property (do_commit && record_any_pickup
    |=> nv_valid && nv_rec.seq == $past(cur.seq))
    else $error("pickup-only record not kept");
  AST_TRIP_FLAG: assert property (do_commit && keep
    |=> nv_rec.tripped == $past(next_cur.tripped))
    else $error("tripped flag lost on store");
  AST_NOTIFY_HOLD: assert property (notify && !notify_ack |=> notify)
    else $error("notification dropped without ack");
  AST_COUNT_MAX: assert property (record_count == 5'(NREC) |=> record_count == 5'(NREC))
    else $error("record count left full");

endmodule
`default_nettype wire

// file: dv/fer_prot_model.sv
// protection module model: drives module pickup and trip levels
`timescale 1ns/100ps
`default_nettype none

module fer_prot_model #(
  parameter int NMOD = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [2:0] pick_idx,
  input wire logic [2:0] trip_idx,
  input wire logic do_trip,
  input wire logic [15:0] trip_at,
  input wire logic [15:0] end_at,
  output logic [NMOD-1:0] mod_pickup,
  output logic [NMOD-1:0] mod_trip,
  output logic busy
);
  logic [15:0] cnt;

  // one fault: pickup first, trip later, both dropped at the end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 16'h0;
      busy <= 1'b0;
      mod_pickup <= '0;
      mod_trip <= '0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      cnt <= 16'h1;
      mod_pickup[pick_idx] <= 1'b1;
    end else if (busy) begin
      cnt <= cnt + 16'h1;
      // trip only while picked up, never before the pickup
      if (do_trip && cnt == trip_at) begin
        mod_trip[trip_idx] <= 1'b1;
      end
      if (cnt == end_at) begin
        busy <= 1'b0;
        mod_pickup <= '0;
        mod_trip <= '0;
      end
    end
  end
endmodule

`default_nettype wire

// file: dv/fer_recorder_test.sv
// self-checking bench of the fault event recorder
`timescale 1ns/100ps
`default_nettype none

module fer_recorder_test
  import fer_pkg::*;
;
  logic clock, reset_n, go, do_trip, rap, ar, sc, ack, pickup_any, trip_any;
  logic notify, rd_valid, nv_valid, busy;
  logic [2:0] pick_idx, trip_idx;
  logic [15:0] trip_at, end_at, meas_value, dly, notify_seq;
  logic [7:0] mod_pickup, mod_trip;
  logic [4:0] rd_age, record_count;
  fer_rec_s rd_rec, nv_rec;
  int fails, samples_checked, exp_seq, exp_grid, exp_cnt, exp_nseq;
  int kept_q[$];

  // short tick so a ms is ten cycles
  fer_recorder #(.NMOD(8), .NREC(20), .TICK_CYCLES(10)) uut (
    .clock(clock), .reset_n(reset_n), .mod_pickup(mod_pickup), .mod_trip(mod_trip),
    .meas_value(meas_value), .meas_delay_ms(dly), .record_any_pickup(rap),
    .ar_cycle_active(ar), .settings_changed(sc), .notify_ack(ack), .rd_age(rd_age),
    .pickup_any(pickup_any), .trip_any(trip_any), .notify(notify),
    .notify_seq(notify_seq), .record_count(record_count), .rd_valid(rd_valid),
    .rd_rec(rd_rec), .nv_valid(nv_valid), .nv_rec(nv_rec));

  fer_prot_model #(.NMOD(8)) prot (
    .clock(clock), .reset_n(reset_n), .go(go), .pick_idx(pick_idx),
    .trip_idx(trip_idx), .do_trip(do_trip), .trip_at(trip_at), .end_at(end_at),
    .mod_pickup(mod_pickup), .mod_trip(mod_trip), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // times carry one tick of phase error
  task automatic chk_near(input logic [15:0] got, input int exp, input string what);
    samples_checked++;
    if ($isunknown(got) || int'(got) > exp + 1 || int'(got) < exp - 1) begin
      fails++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // one fault through the model, then the stored record is checked
  task automatic fault(input logic [2:0] p, input logic [2:0] t, input logic tr,
                       input logic [15:0] ta, input logic [15:0] ea);
    logic [15:0] ma, mb;
    logic kept;
    int n;
    // let mode changes made just before the call settle first
    @(posedge clock);
    ma = 16'($urandom);
    mb = ~ma;
    kept = tr | rap;
    exp_seq++;
    exp_grid += ar ? 0 : 1;
    meas_value <= ma;
    {pick_idx, trip_idx, do_trip, trip_at, end_at, go} <= {p, t, tr, ta, ea, 1'b1};
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
    chk(16'(pickup_any), 16'h1, "pickup_any");
    n = 0;
    while (tr && trip_any !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    if (tr) chk(16'(trip_any), 16'h1, "trip_any");
    // value after the trip must not reach a zero-delay record
    meas_value <= mb;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clock);
      n++;
    end
    repeat (3) @(posedge clock);
    if (kept) begin
      exp_cnt = (exp_cnt < 20) ? exp_cnt + 1 : 20;
      exp_nseq = exp_seq;
      kept_q.push_back(exp_seq);
      chk(rd_rec.seq, 16'(exp_seq), "seq");
      chk(rd_rec.grid, 16'(exp_grid), "grid");
      chk(16'(rd_rec.tripped), 16'(tr), "tripped");
      chk(16'(rd_rec.ttt_valid), 16'(tr && p == t), "ttt_valid");
      if (tr && p == t) chk_near(rd_rec.ttt, (ta - 1) / 10, "ttt");
      chk_near(rd_rec.dur, (ea - 1) / 10, "dur");
      if (tr) chk(rd_rec.meas, (dly == 0) ? ma : mb, "meas");
      chk(16'(rd_rec.changed), 16'h0, "changed");
      chk(nv_rec.seq, 16'(exp_seq), "nv seq");
      chk(16'(nv_valid), 16'h1, "nv valid");
    end
    chk(16'(record_count), 16'(exp_cnt), "count");
    chk(16'(notify), 16'h1, "notify");
    chk(notify_seq, 16'(exp_nseq), "notify_seq");
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    repeat (2) @(posedge clock);
    chk(16'(notify), 16'h0, "notify ack");
  endtask

  // cut a hang short well beyond the expected run
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    results();
  end

  initial begin
    reset_n = 1'b0;
    {go, do_trip, ar, sc, ack, pick_idx, trip_idx, rd_age} = '0;
    {trip_at, end_at, meas_value, dly} = '0;
    rap = 1'b1;
    {fails, samples_checked, exp_seq, exp_grid, exp_cnt, exp_nseq} = '0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    void'($urandom(32'h5936));
    repeat (2) @(posedge clock);
    chk(16'(record_count), 16'h0, "reset count");
    chk(16'(rd_valid), 16'h0, "reset rd_valid");
    // corner cases: same module, other module, delayed capture
    fault(3'd2, 3'd2, 1'b1, 16'd25, 16'd60);
    fault(3'd1, 3'd4, 1'b1, 16'd15, 16'd50);
    dly <= 16'd2;
    fault(3'd3, 3'd3, 1'b1, 16'd20, 16'd80);
    dly <= 16'd0;
    fault(3'd0, 3'd0, 1'b0, 16'd10, 16'd35);
    rap <= 1'b0;
    fault(3'd5, 3'd5, 1'b0, 16'd10, 16'd35);
    ar <= 1'b1;
    fault(3'd7, 3'd7, 1'b1, 16'd12, 16'd40);
    ar <= 1'b0;
    // random faults overflow the store
    repeat (30) begin
      rap <= 1'($urandom);
      fault(3'($urandom), 3'($urandom % 2 ? 0 : 1), 1'($urandom % 4 != 0),
            16'(5 + $urandom % 30), 16'(40 + $urandom % 30));
    end
    rd_age <= 5'd19;
    repeat (3) @(posedge clock);
    chk(16'(record_count), 16'd20, "full count");
    chk(16'(rd_valid), 16'h1, "oldest valid");
    chk(rd_rec.seq, 16'(kept_q[kept_q.size() - 20]), "oldest seq");
    sc <= 1'b1;
    @(posedge clock);
    sc <= 1'b0;
    rd_age <= 5'd0;
    repeat (3) @(posedge clock);
    chk(16'(rd_rec.changed), 16'h1, "changed");
    chk(16'(nv_rec.changed), 16'h1, "nv changed");
    results();
  end
endmodule

`default_nettype wire
